// ===== include/bidir_fifo_pkg.sv
/*
  Constants shared by the bidirectional queue design: register map,
  field layout, reset values, widths.
  Assumes a single clock and an AXI4-Lite master on side A.
*/
package bidir_fifo_pkg;
  localparam int          DATA_W      = 36;
  localparam int          AXI_AW      = 8;
  localparam int          OFF_W       = 11;
  localparam int          DEF_AW      = 8;
  localparam logic [10:0] OFFSET_RST  = 11'h008;
  localparam logic [7:0]  ADR_CTRL    = 8'h00;
  localparam logic [7:0]  ADR_OFFS1   = 8'h04;
  localparam logic [7:0]  ADR_OFFS2   = 8'h08;
  localparam logic [7:0]  ADR_STATUS  = 8'h0C;
  localparam logic [7:0]  ADR_QDATA   = 8'h10;
  localparam logic [7:0]  ADR_QREAD   = 8'h14;
  localparam logic [7:0]  ADR_MAIL    = 8'h18;
  localparam int          FALL_THROUGH_MODE_BIT    = 0;
  localparam int          OFF_Y_POS   = 16;
  localparam logic [31:0] OFFS_MASK   = 32'h07FF07FF;
  localparam logic [31:0] CTRL_MASK   = 32'h00000001;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// ===== design/bidir_fifo_status_flags.sv
/*
  Bidirectional queue pair with flag logic, mailboxes, side B pin
  decode and an AXI4-Lite slave acting as side A.
  Assumes side B pins are synchronous to aclk.
*/
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// one queue: memory, pointers, flag pipelines
module queue_core #(
  parameter int AW = bidir_fifo_pkg::DEF_AW
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              fall_through_mode,
  input  wire logic                              wr_req,
  input  wire logic [bidir_fifo_pkg::DATA_W-1:0] wr_data,
  input  wire logic                              rd_req,
  input  wire logic [bidir_fifo_pkg::OFF_W-1:0]  ae_off,
  input  wire logic [bidir_fifo_pkg::OFF_W-1:0]  af_off,
  output logic                                   wr_ready,
  output logic                                   rd_flag,
  output logic                                   almost_empty,
  output logic                                   almost_full,
  output logic [bidir_fifo_pkg::DATA_W-1:0]      rd_data
);
  import bidir_fifo_pkg::*;

  localparam int         DEPTH    = 1 << AW;
  localparam logic [AW:0] FULL_CNT = {1'b1, {AW{1'b0}}};

  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW:0]       wptr_reg;
  logic [AW:0]       wgray_reg;
  logic [AW:0]       rptr_reg;
  logic [AW:0]       rgray_reg;
  logic [AW:0]       wg_s1_reg;
  logic [AW:0]       wg_s2_reg;
  logic [AW:0]       rg_s1_reg;
  logic [AW:0]       rg_s2_reg;
  logic              or_reg;
  logic [AW:0]       rcount;
  logic [AW:0]       wcount;
  logic              have_word;
  logic              load;
  logic              wr_fire;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    gray2bin[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      gray2bin[i] = gray2bin[i+1] ^ g[i];
    end
  endfunction

  // ==========================================================
  // flag arithmetic
  // word in rd_data already left memory, so counts exclude it
  assign rcount    = gray2bin(wg_s2_reg) - rptr_reg;
  assign wcount    = wptr_reg - gray2bin(rg_s2_reg);
  assign wr_ready  = (wcount != FULL_CNT);
  assign wr_fire   = wr_req && wr_ready;
  assign have_word = (rcount != '0);
  assign load      = have_word && (fall_through_mode ? (!or_reg || rd_req) : rd_req);
  assign rd_flag   = fall_through_mode ? or_reg : have_word;
  assign almost_empty = OFF_W'(rcount) > ae_off;
  assign almost_full  = OFF_W'(wcount) < (OFF_W'(FULL_CNT) - af_off);

  // ==========================================================
  // write side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_reg  <= '0;
      wgray_reg <= '0;
    end else if (wr_fire) begin
      wptr_reg  <= wptr_reg + 1'b1;
      wgray_reg <= bin2gray(wptr_reg + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_fire) begin
      mem[wptr_reg[AW-1:0]] <= wr_data;
    end
  end

  // ==========================================================
  // read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rptr_reg  <= '0;
      rgray_reg <= '0;
      rd_data   <= '0;
    end else if (load) begin
      rd_data   <= mem[rptr_reg[AW-1:0]];
      rptr_reg  <= rptr_reg + 1'b1;
      rgray_reg <= bin2gray(rptr_reg + 1'b1);
    end
  end

  // fall-through ready: set by a load, dropped by a read with nothing behind
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      or_reg <= 1'b0;
    end else if (!fall_through_mode) begin
      or_reg <= 1'b0;
    end else if (load) begin
      or_reg <= 1'b1;
    end else if (rd_req) begin
      or_reg <= 1'b0;
    end
  end

  // ==========================================================
  // pointer crossing, two stages each way
  // with one clock the skew window is always met, so counting
  // starts at the second edge after the write or read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  // ==========================================================
  // checks
  AST_FULL_DROP:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_req && !wr_ready) |=> $stable(wptr_reg))
    else $error("write taken while full");

  AST_WPTR_STEP:
    assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> (wptr_reg == $past(wptr_reg) + 1'b1))
    else $error("write pointer did not step");

  AST_STD_HOLD:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (!fall_through_mode && !rd_flag) |=> ($stable(rd_data) && $stable(rptr_reg)))
    else $error("output changed while empty");

  AST_FALL_THROUGH_MODE_HOLD:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (fall_through_mode && !rd_flag && !have_word) |=> $stable(rd_data))
    else $error("output changed while not ready");

  AST_STD_LAT:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (!fall_through_mode && wr_fire && wptr_reg == rptr_reg) |=> !rd_flag [*2] ##1 (rd_flag || fall_through_mode))
    else $error("empty flag not raised on second edge");

  AST_FALL_THROUGH_MODE_LAT:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (fall_through_mode && !or_reg && wr_fire && wptr_reg == rptr_reg) |=>
        (fall_through_mode && !rd_flag) [*3] ##1 (!fall_through_mode || (rd_flag && rd_data == $past(wr_data, 4))))
    else $error("fall-through word not loaded on third edge");

  AST_FULL_LAT:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (!wr_ready && load) |=> !wr_ready [*2] ##1 wr_ready)
    else $error("full flag not released on second edge");
endmodule

// ==========================================================
// top: AXI4-Lite side A, pin side B, two queues, two mailboxes
module bidir_fifo_status_flags #(
  parameter int AW = bidir_fifo_pkg::DEF_AW
) (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic [bidir_fifo_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [bidir_fifo_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              side_b_select_n,
  input  wire logic                              side_b_direction,
  input  wire logic                              side_b_enable,
  input  wire logic                              side_b_mailbox_sel,
  input  wire logic [bidir_fifo_pkg::DATA_W-1:0] side_b_data_in,
  output logic [bidir_fifo_pkg::DATA_W-1:0]      side_b_data_out,
  output logic                                   side_b_data_oe,
  output logic                                   side_a_empty_or_ready,
  output logic                                   side_a_almost_empty,
  output logic                                   side_a_full_or_ready,
  output logic                                   side_a_almost_full,
  output logic                                   side_b_empty_or_ready,
  output logic                                   side_b_almost_empty,
  output logic                                   side_b_full_or_ready,
  output logic                                   side_b_almost_full,
  output logic                                   a_to_b_mail_flag,
  output logic                                   b_to_a_mail_flag
);
  import bidir_fifo_pkg::*;

  logic [31:0]       ctrl_reg;
  logic [31:0]       offs1_reg;
  logic [31:0]       offs2_reg;
  logic [DATA_W-1:0] mail_ab_reg;
  logic [DATA_W-1:0] mail_ba_reg;
  logic [DATA_W-1:0] ab_data;
  logic [DATA_W-1:0] ba_data;
  logic [31:0]       rdata_next;
  logic [1:0]        rresp_next;
  logic              wr_go;
  logic              rd_go;
  logic              b_act;
  logic              a_push;
  logic              a_pop;
  logic              a_mail_wr;
  logic              a_mail_rd;
  logic              b_push;
  logic              b_pop;
  logic              b_mail_wr;
  logic              b_mail_rd;
  logic              fall_through_mode;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a == ADR_CTRL) || (a == ADR_OFFS1) || (a == ADR_OFFS2)
          || (a == ADR_STATUS) || (a == ADR_QDATA) || (a == ADR_QREAD)
          || (a == ADR_MAIL);
  endfunction

  assign fall_through_mode = ctrl_reg[FALL_THROUGH_MODE_BIT];

  // ==========================================================
  // side B pin decode
  assign b_act     = !side_b_select_n && side_b_enable;
  assign b_push    = b_act && !side_b_direction && !side_b_mailbox_sel;
  assign b_pop     = b_act && side_b_direction && !side_b_mailbox_sel;
  assign b_mail_wr = b_act && !side_b_direction && side_b_mailbox_sel;
  assign b_mail_rd = b_act && side_b_direction && side_b_mailbox_sel;
  assign side_b_data_oe  = !side_b_select_n && side_b_direction;
  assign side_b_data_out = side_b_mailbox_sel ? mail_ab_reg : ab_data;

  // ==========================================================
  // side A over the register bus
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign a_push    = wr_go && (s_axi_awaddr == ADR_QDATA);
  assign a_pop     = wr_go && (s_axi_awaddr == ADR_QREAD);
  assign a_mail_wr = wr_go && (s_axi_awaddr == ADR_MAIL);
  assign a_mail_rd = rd_go && (s_axi_araddr == ADR_MAIL);

  // ==========================================================
  // queues
  queue_core #(.AW(AW)) u_a_to_b (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .fall_through_mode         (fall_through_mode),
    .wr_req       (a_push),
    .wr_data      ({4'h0, s_axi_wdata}),
    .rd_req       (b_pop),
    .ae_off       (offs1_reg[OFF_W-1:0]),
    .af_off       (offs1_reg[OFF_Y_POS +: OFF_W]),
    .wr_ready     (side_a_full_or_ready),
    .rd_flag      (side_b_empty_or_ready),
    .almost_empty (side_b_almost_empty),
    .almost_full  (side_a_almost_full),
    .rd_data      (ab_data)
  );

  queue_core #(.AW(AW)) u_b_to_a (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .fall_through_mode         (fall_through_mode),
    .wr_req       (b_push),
    .wr_data      (side_b_data_in),
    .rd_req       (a_pop),
    .ae_off       (offs2_reg[OFF_W-1:0]),
    .af_off       (offs2_reg[OFF_Y_POS +: OFF_W]),
    .wr_ready     (side_b_full_or_ready),
    .rd_flag      (side_a_empty_or_ready),
    .almost_empty (side_a_almost_empty),
    .almost_full  (side_b_almost_full),
    .rd_data      (ba_data)
  );

  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg  <= '0;
      offs1_reg <= {5'h00, OFFSET_RST, 5'h00, OFFSET_RST};
      offs2_reg <= {5'h00, OFFSET_RST, 5'h00, OFFSET_RST};
    end else if (wr_go) begin
      if (s_axi_awaddr == ADR_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, s_axi_wdata, s_axi_wstrb) & CTRL_MASK;
      end else if (s_axi_awaddr == ADR_OFFS1) begin
        offs1_reg <= merge(offs1_reg, s_axi_wdata, s_axi_wstrb) & OFFS_MASK;
      end else if (s_axi_awaddr == ADR_OFFS2) begin
        offs2_reg <= merge(offs2_reg, s_axi_wdata, s_axi_wstrb) & OFFS_MASK;
      end
    end
  end

  // ==========================================================
  // mailboxes; flag low means mail waiting
  // a write is only taken while the flag is high, so a same-cycle
  // read and write leave the new mail flagged when the flag was high;
  // with the flag low the write is dropped and the read raises it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mail_ab_reg      <= '0;
      a_to_b_mail_flag <= 1'b1;
    end else if (a_mail_wr && a_to_b_mail_flag) begin
      mail_ab_reg      <= {4'h0, s_axi_wdata};
      a_to_b_mail_flag <= 1'b0;
    end else if (b_mail_rd) begin
      a_to_b_mail_flag <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mail_ba_reg      <= '0;
      b_to_a_mail_flag <= 1'b1;
    end else if (b_mail_wr && b_to_a_mail_flag) begin
      mail_ba_reg      <= side_b_data_in;
      b_to_a_mail_flag <= 1'b0;
    end else if (a_mail_rd) begin
      b_to_a_mail_flag <= 1'b1;
    end
  end

  // ==========================================================
  // read data select
  always_comb begin
    rdata_next = '0;
    rresp_next = RESP_OKAY;
    if (s_axi_araddr == ADR_CTRL) begin
      rdata_next = ctrl_reg;
    end else if (s_axi_araddr == ADR_OFFS1) begin
      rdata_next = offs1_reg;
    end else if (s_axi_araddr == ADR_OFFS2) begin
      rdata_next = offs2_reg;
    end else if (s_axi_araddr == ADR_STATUS) begin
      rdata_next[9:0] = {b_to_a_mail_flag, a_to_b_mail_flag,
                         side_b_almost_full, side_b_full_or_ready,
                         side_b_almost_empty, side_b_empty_or_ready,
                         side_a_almost_full, side_a_full_or_ready,
                         side_a_almost_empty, side_a_empty_or_ready};
    end else if (s_axi_araddr == ADR_QDATA) begin
      rdata_next = ba_data[31:0]; // upper four bits not visible to side A
    end else if (s_axi_araddr == ADR_MAIL) begin
      rdata_next = mail_ba_reg[31:0];
    end else if (!mapped(s_axi_araddr)) begin
      rresp_next = RESP_SLVERR;
    end
  end

  // ==========================================================
  // bus responses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_next;
      s_axi_rresp  <= rresp_next;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  AST_MAIL_HOLD:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (!a_to_b_mail_flag && a_mail_wr) |=> $stable(mail_ab_reg))
    else $error("mailbox overwritten while flag low");

  AST_MAIL_READ:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (b_mail_rd && !(a_mail_wr && a_to_b_mail_flag)) |=> a_to_b_mail_flag)
    else $error("mail flag not raised by side B read");
endmodule

`default_nettype wire

// ===== verif/side_b_agent.sv
/*
  Side B pin agent: drives queue and mailbox cycles on the pin side
  and hands back each word it reads.
  Assumes the pins are sampled on rising aclk edges; tasks are called
  just after an edge.
*/
`timescale 1ns/1ns
`default_nettype none

module side_b_agent (
  input  wire logic        aclk,
  input  wire logic [35:0] data_out,
  output logic             select_n,
  output logic             direction,
  output logic             enable,
  output logic             mailbox_sel,
  output logic [35:0]      data_in,
  output logic             got_v,
  output logic [35:0]      got
);
  initial begin
    select_n = 1'b1;
    direction = 1'b0;
    enable = 1'b0;
    mailbox_sel = 1'b0;
    data_in = 36'h0;
    got_v = 1'b0;
    got = 36'h0;
  end

  // ==========================================================
  // one port cycle
  // read data is sampled one edge after the load edge
  task automatic op(input logic dir, input logic mb, input logic [35:0] d);
    select_n <= 1'b0;
    direction <= dir;
    enable <= 1'b1;
    mailbox_sel <= mb;
    data_in <= d;
    @(posedge aclk);
    enable <= 1'b0;
    // released bus shows the inverse, never a stale copy
    data_in <= ~d;
    if (dir) begin
      @(posedge aclk);
      got <= data_out;
      got_v <= 1'b1;
    end
    select_n <= 1'b1;
    @(posedge aclk);
    got_v <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ===== verif/tb_top.sv
/*
  Self-checking bench for the bidirectional queue block.
  Assumes the design package is compiled first and one shared aclk.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin check_count++; if (((g) & (m)) !== ((e) & (m))) begin \
  failures++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
  import bidir_fifo_pkg::*;
  typedef struct {
    logic [35:0] v;
    logic [35:0] m;
  } note_t;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, side_b_select_n, side_b_direction, side_b_enable;
  logic        side_b_mailbox_sel, side_b_data_oe, side_a_empty_or_ready;
  logic        side_a_almost_empty, side_a_full_or_ready, side_a_almost_full;
  logic        side_b_empty_or_ready, side_b_almost_empty, side_b_full_or_ready;
  logic        side_b_almost_full, a_to_b_mail_flag, b_to_a_mail_flag, got_v;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, wd;
  logic [35:0] side_b_data_in, side_b_data_out, got, w;
  note_t       qa[$], qb[$];
  logic [35:0] mdl[$];
  int          failures, check_count, cyc, k;
  int          seed = 32'hb076;

  // depth 8 keeps the fill test short
  bidir_fifo_status_flags #(.AW(3)) bidir_fifo_status_flags_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .side_b_select_n, .side_b_direction,
    .side_b_enable, .side_b_mailbox_sel, .side_b_data_in, .side_b_data_out,
    .side_b_data_oe, .side_a_empty_or_ready, .side_a_almost_empty,
    .side_a_full_or_ready, .side_a_almost_full, .side_b_empty_or_ready,
    .side_b_almost_empty, .side_b_full_or_ready, .side_b_almost_full,
    .a_to_b_mail_flag, .b_to_a_mail_flag
  );

  side_b_agent side_b_agent_inst (
    .aclk, .data_out(side_b_data_out), .select_n(side_b_select_n),
    .direction(side_b_direction), .enable(side_b_enable),
    .mailbox_sel(side_b_mailbox_sel), .data_in(side_b_data_in), .got_v, .got
  );

  // ==========================================================
  // clock, timeout, verdict
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // monitor: oldest note against each result
  task automatic cmp(input note_t n, input logic [35:0] g);
    `CHK(g, n.v, n.m)
  endtask

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp(qa.pop_front(), {34'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) cmp(qa.pop_front(), {2'h0, s_axi_rresp, s_axi_rdata});
    if (got_v) cmp(qb.pop_front(), got);
  end

  // ==========================================================
  // register bus master
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    qa.push_back('{{34'h0, r}, 36'h3});
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                        input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    qa.push_back('{{2'h0, r, e}, {4'h3, m}});
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    #1 `CHK(side_b_data_oe, 1'b0, 1'b1)
    // depth 8 with offset 8: almost-full already low at zero words
    axi_rd(ADR_STATUS, 32'h344, 32'h3FF, RESP_OKAY);
    axi_rd(ADR_CTRL, 32'h0, 32'h1, RESP_OKAY);
    axi_wr(8'h40, 32'h0, RESP_SLVERR);
    axi_rd(8'h40, 32'h0, 32'h0, RESP_SLVERR);
    $display("done: reset and map");
    // both modes: flag latency seen at side A after a side B push
    for (int m = 0; m < 2; m++) begin
      axi_wr(ADR_CTRL, 32'(m), RESP_OKAY);
      w = 36'({$random(seed), $random(seed)});
      side_b_agent_inst.op(1'b0, 1'b0, w);
      repeat (m) @(posedge aclk);
      #1 `CHK(side_a_empty_or_ready, 1'b0, 1'b1)
      @(posedge aclk);
      #1 `CHK(side_a_empty_or_ready, 1'b1, 1'b1)
      if (m == 0) axi_wr(ADR_QREAD, 32'h0, RESP_OKAY);
      axi_rd(ADR_QDATA, w[31:0], 32'hFFFFFFFF, RESP_OKAY);
    end
    axi_wr(ADR_CTRL, 32'h0, RESP_OKAY);
    $display("done: flag latency");
    // fill a_to_b to full and one beyond, thresholds 2 and 2
    axi_wr(ADR_OFFS1, 32'h00020002, RESP_OKAY);
    axi_wr(ADR_OFFS2, 32'h00020002, RESP_OKAY);
    for (int i = 1; i <= 9; i++) begin
      wd = $random(seed);
      if (i < 9) mdl.push_back({4'h0, wd});
      axi_wr(ADR_QDATA, wd, RESP_OKAY);
      repeat (3) @(posedge aclk);
      k = (i > 8) ? 8 : i;
      axi_rd(ADR_STATUS, {24'h0, 2'b11, k > 2, 1'b1, k < 6, k < 8, 2'b00},
             32'hFF, RESP_OKAY);
    end
    $display("done: fill");
    // drain from side B; the extra read must leave the last word
    for (int i = 0; i < 9; i++) begin
      if (i < 8) w = mdl.pop_front();
      qb.push_back('{w, '1});
      side_b_agent_inst.op(1'b1, 1'b0, 36'h0);
    end
    repeat (3) @(posedge aclk);
    axi_rd(ADR_STATUS, 32'h0C, 32'h3C, RESP_OKAY);
    $display("done: drain");
    // mailboxes both ways, second write while full dropped
    wd = $random(seed);
    axi_wr(ADR_MAIL, wd, RESP_OKAY);
    axi_wr(ADR_MAIL, ~wd, RESP_OKAY);
    axi_rd(ADR_STATUS, 32'h0, 32'h100, RESP_OKAY);
    qb.push_back('{{4'h0, wd}, '1});
    side_b_agent_inst.op(1'b1, 1'b1, 36'h0);
    w = 36'({$random(seed), $random(seed)});
    side_b_agent_inst.op(1'b0, 1'b1, w);
    side_b_agent_inst.op(1'b0, 1'b1, ~w);
    axi_rd(ADR_STATUS, 32'h100, 32'h300, RESP_OKAY);
    axi_rd(ADR_MAIL, w[31:0], 32'hFFFFFFFF, RESP_OKAY);
    axi_rd(ADR_STATUS, 32'h300, 32'h300, RESP_OKAY);
    $display("done: mailboxes");
    repeat (5) @(posedge aclk);
    end_sim();
  end
endmodule

`default_nettype wire
